// File: logic/temp_compare.sv
`timescale 1ns/100ps
module temp_compare
	import temp_monitor_pkg::*;
(
	// Reading and references
	input wire logic signed [TEMP_W-1:0] reading_i,
	input wire logic signed [TEMP_W-1:0] baseline_i,
	input wire logic [7:0] limits_i,
	input wire logic [1:0] delta_code_i,
	// Limit hits
	output temp_irq_t hit_o
);
	logic signed [TEMP_W:0] diff;
	logic [TEMP_W:0] mag;
	logic signed [TEMP_W-1:0] cold_deg;
	logic signed [TEMP_W-1:0] hot_deg;
	logic [TEMP_W:0] delta_deg;

	always_comb begin
		diff = TEMP_W'(0) + ((TEMP_W+1)'(reading_i) - (TEMP_W+1)'(baseline_i));
		mag = diff[TEMP_W] ? (TEMP_W+1)'(-diff) : (TEMP_W+1)'(diff);
		delta_deg = (TEMP_W+1)'(DELTA_BASE) + (TEMP_W+1)'(delta_code_i);
		cold_deg = COLD_BASE + TEMP_W'(limits_i[7:4]);
		hot_deg = HOT_BASE + TEMP_W'(limits_i[3:0]);
		hit_o.change = mag >= delta_deg;
		hit_o.cold = reading_i <= cold_deg;
		hit_o.hot = reading_i >= hot_deg;
	end
endmodule // temp_compare

// File: logic/temp_monitor_pkg.sv
// What this block does
// - Writing one to the start bit of the control register begins an acquisition; writing zero does nothing.
// - The start bit clears itself once the acquisition completes.
// - The done flag reads one when no conversion runs, zero while one runs, and one after reset.
// - The two-bit change threshold selects 2, 3, 4 or 5 degrees C for codes 00 to 11.
// - A change interrupt is raised when a reading other than the first after reset differs from the baseline by at least the threshold.
// - The cold limit in the upper nibble maps 0000 to -7 C up to 8 C; an interrupt fires at or below it.
// - The hot limit in the lower nibble maps 0000 to 42 C up to 57 C; an interrupt fires at or above it.
package temp_monitor_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_ACQ_CTRL = 8'h0D;
	localparam logic [7:0] ADDR_LIMITS = 8'h0E;
	localparam logic [7:0] RST_ACQ_CTRL = 8'h20;
	localparam logic [7:0] RST_LIMITS = 8'h78;
	// Writable bits of the control register (done flag is read only)
	localparam logic [7:0] ACQ_CTRL_WMASK = 8'hDF;
	localparam int START_BIT = 7;
	localparam int DONE_BIT = 5;
	// ----------------------------------------
	// Temperature encodings, signed degrees C
	// ----------------------------------------
	localparam int TEMP_W = 8;
	localparam logic signed [7:0] DELTA_BASE = 8'sh02;
	localparam logic signed [7:0] COLD_BASE = -8'sh07;
	localparam logic signed [7:0] HOT_BASE = 8'sh2A;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic cold;
		logic hot;
		logic change;
	} temp_irq_t;
endpackage

// File: logic/thermistor_temp_monitor.sv
`timescale 1ns/100ps
module thermistor_temp_monitor
	import temp_monitor_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Register port
	input wire reg_req_t req_i,
	output logic [7:0] rdata_o,
	// Converter handshake, same clock
	output logic conv_start_o,
	input wire logic conv_done_i,
	input wire logic signed [TEMP_W-1:0] conv_result_i,
	// Interrupt events, one cycle
	output temp_irq_t irq_o
);
	logic rst_meta;
	logic rst_sync_n;
	logic start_bit;
	logic done_bit;
	logic [7:0] ctrl_rw;
	logic [7:0] acq_ctrl;
	logic start_wr;
	logic acq_end;
	logic [7:0] limits;
	logic signed [TEMP_W-1:0] reading;
	logic signed [TEMP_W-1:0] baseline;
	logic have_reading;
	logic fresh;
	temp_irq_t hit;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CONV = 2'b10
	} acq_state_t;
	acq_state_t state;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// ----------------------------------------
	// Acquisition sequencing
	// ----------------------------------------
	// Register write to one address this cycle
	function automatic logic write_hit(input reg_req_t r,
		input logic [7:0] a);
		return r.wr && r.addr == a;
	endfunction

	// Value a read of one address returns; unmapped reads give zero
	function automatic logic [7:0] read_mux(input logic [7:0] a,
		input logic [7:0] ctrl, input logic [7:0] lim);
		case (a)
			ADDR_ACQ_CTRL: return ctrl;
			ADDR_LIMITS: return lim;
			default: return '0;
		endcase
	endfunction

	assign start_wr = write_hit(req_i, ADDR_ACQ_CTRL)
		&& req_i.wdata[START_BIT];
	assign acq_end = state == ST_CONV && conv_done_i;

	always_ff @(posedge clk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state <= ST_IDLE;
			conv_start_o <= 1'b0;
		end else begin
			conv_start_o <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (start_wr) begin
						state <= ST_CONV;
						conv_start_o <= 1'b1;
					end
				end
				ST_CONV: begin
					if (conv_done_i)
						state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	// Plain read/write bits; start and done live in their own flops
	always_ff @(posedge clk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl_rw <= RST_ACQ_CTRL & ACQ_CTRL_WMASK;
		end else if (write_hit(req_i, ADDR_ACQ_CTRL)) begin
			ctrl_rw <= req_i.wdata & ACQ_CTRL_WMASK;
		end
	end

	// Zero in the start bit never cancels a running acquisition
	always_ff @(posedge clk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			start_bit <= RST_ACQ_CTRL[START_BIT];
		end else if (acq_end) begin
			start_bit <= 1'b0;
		end else if (start_wr) begin
			start_bit <= 1'b1;
		end
	end

	// Done drops when a start is taken and returns with the result
	always_ff @(posedge clk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			done_bit <= RST_ACQ_CTRL[DONE_BIT];
		end else if (acq_end) begin
			done_bit <= 1'b1;
		end else if (state == ST_IDLE && start_wr) begin
			done_bit <= 1'b0;
		end
	end

	always_comb begin
		acq_ctrl = ctrl_rw;
		acq_ctrl[START_BIT] = start_bit;
		acq_ctrl[DONE_BIT] = done_bit;
	end

	// ----------------------------------------
	// Limits register and read port
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			limits <= RST_LIMITS;
		end else if (write_hit(req_i, ADDR_LIMITS)) begin
			limits <= req_i.wdata;
		end
	end

	// Read data holds between reads
	always_ff @(posedge clk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rdata_o <= '0;
		end else if (req_i.rd) begin
			rdata_o <= read_mux(req_i.addr, acq_ctrl, limits);
		end
	end

	// ----------------------------------------
	// Reading, baseline and limit checks
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			fresh <= 1'b0;
		end else begin
			fresh <= acq_end;
		end
	end

	// Reading is kept for the compare until the next result
	always_ff @(posedge clk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reading <= '0;
		end else if (acq_end) begin
			reading <= conv_result_i;
		end
	end

	temp_compare u_compare (
		.reading_i(reading),
		.baseline_i(baseline),
		.limits_i(limits),
		.delta_code_i(acq_ctrl[1:0]),
		.hit_o(hit)
	);

	// ----------------------------------------
	// Baseline tracking
	// ----------------------------------------
	// First reading only sets the baseline, so no spurious change event
	always_ff @(posedge clk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			have_reading <= 1'b0;
		end else if (fresh) begin
			have_reading <= 1'b1;
		end
	end

	// Reload after a change event, so drift is measured in steps
	always_ff @(posedge clk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			baseline <= '0;
		end else if (fresh && (!have_reading || hit.change)) begin
			baseline <= reading;
		end
	end

	// ----------------------------------------
	// Interrupt events, one cycle each
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq_o <= '0;
		end else if (fresh) begin
			irq_o.cold <= hit.cold;
			irq_o.hot <= hit.hot;
			irq_o.change <= have_reading && hit.change;
		end else begin
			irq_o <= '0;
		end
	end
endmodule // thermistor_temp_monitor

// File: testbench/conv_model.sv
`timescale 1ns/100ps
module conv_model
	import temp_monitor_pkg::*;
(
	// Converter side
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic signed [TEMP_W-1:0] temp_i,
	input wire logic [3:0] wait_i,
	output logic done_o,
	output logic signed [TEMP_W-1:0] res_o
);
	initial begin
		done_o = 1'h0;
		res_o = '0;
	end
	// Result is garbled outside the done cycle
	always @(posedge clk_i) begin
		if (start_i) begin
			repeat (wait_i) @(posedge clk_i);
			done_o <= 1'h1;
			res_o <= temp_i;
			@(posedge clk_i);
			done_o <= 1'h0;
			res_o <= ~temp_i;
		end
	end
endmodule // conv_model

// File: testbench/temp_monitor_checker.sv
`timescale 1ns/100ps
module temp_monitor_checker
	import temp_monitor_pkg::*;
(
	// Watched ports
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire reg_req_t req_i,
	input wire logic [7:0] rdata_o,
	input wire logic conv_start_o,
	input wire logic conv_done_i,
	input wire logic signed [TEMP_W-1:0] conv_result_i,
	input wire temp_irq_t irq_o
);
	logic busy;
	logic [7:0] lim;
	logic wst;
	assign wst = req_i.wr && req_i.addr == ADDR_ACQ_CTRL
		&& req_i.wdata[START_BIT];
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) busy <= 1'h0;
		else if (conv_start_o) busy <= 1'h1;
		else if (conv_done_i) busy <= 1'h0;
	end
	// Shadow of the limits, so reads and hits can be predicted
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) lim <= RST_LIMITS;
		else if (req_i.wr && req_i.addr == ADDR_LIMITS) lim <= req_i.wdata;
	end
	// ----
	// Assertions
	// ----
	a_start_go: assert property (wst && !busy && !conv_start_o |=> conv_start_o)
		else $error("start write gave no start");
	a_zero_idle: assert property (!wst |=> !conv_start_o)
		else $error("start without request");
	a_done_busy: assert property (busy && !conv_done_i && req_i.rd &&
		req_i.addr == ADDR_ACQ_CTRL |=> !rdata_o[5])
		else $error("done flag set while busy");
	a_irq_time: assert property (irq_o != 3'h0 |-> $past(conv_done_i, 2))
		else $error("irq outside evaluation slot");
	a_cold_hit: assert property ($past(conv_done_i, 2) |-> irq_o.cold ==
		($past(conv_result_i, 2) <= $signed({4'h0, lim[7:4]}) - 8'sh07))
		else $error("cold irq wrong");
	a_hot_hit: assert property ($past(conv_done_i, 2) |-> irq_o.hot ==
		($past(conv_result_i, 2) >= $signed({4'h0, lim[3:0]}) + 8'sh2A))
		else $error("hot irq wrong");
	a_lim_read: assert property (req_i.rd && req_i.addr == ADDR_LIMITS |=>
		rdata_o == lim) else $error("limits read wrong");
	a_rdata_hold: assert property (!req_i.rd |=> $stable(rdata_o))
		else $error("read data moved");
	cover property (irq_o.change);
	cover property (irq_o.cold);
	cover property (irq_o.hot);
endmodule // temp_monitor_checker
bind thermistor_temp_monitor temp_monitor_checker i_temp_monitor_checker (
	.clk_i, .nrst_i, .req_i, .rdata_o, .conv_start_o, .conv_done_i,
	.conv_result_i, .irq_o);

// File: testbench/thermistor_temp_monitor_tb.sv
`timescale 1ns/100ps
module thermistor_temp_monitor_tb
	import temp_monitor_pkg::*;
;
	logic clk_i = 1'h0;
	logic nrst_i = 1'h0;
	reg_req_t req = '0;
	logic [7:0] rdata_o, q;
	logic conv_start_o, conv_done_i;
	logic signed [TEMP_W-1:0] conv_result_i, temp = 8'h00;
	logic [3:0] cwait = 4'h4;
	temp_irq_t irq_o, seen;
	int errors = 0;
	int cmp_count = 0;
	// Control, limits, reading, expected {cold,hot,change}
	logic [7:0] rows [11][4] = '{'{8'h80, 8'h78, 8'h14, 8'h00},
		'{8'h80, 8'h78, 8'h15, 8'h00}, '{8'h80, 8'h78, 8'h16, 8'h01},
		'{8'h81, 8'h78, 8'h18, 8'h00}, '{8'h81, 8'h78, 8'h19, 8'h01},
		'{8'h82, 8'h78, 8'h1D, 8'h01}, '{8'h83, 8'hFF, 8'h08, 8'h05},
		'{8'h83, 8'hFF, 8'h39, 8'h03}, '{8'h80, 8'h00, 8'h2A, 8'h03},
		'{8'h80, 8'h00, 8'hF9, 8'h05}, '{8'h80, 8'h00, 8'hFA, 8'h00}};
	always #5 clk_i = ~clk_i;
	thermistor_temp_monitor i_thermistor_temp_monitor (.clk_i, .nrst_i,
		.req_i(req), .rdata_o, .conv_start_o, .conv_done_i, .conv_result_i,
		.irq_o);
	conv_model i_conv_model (.clk_i, .start_i(conv_start_o), .temp_i(temp),
		.wait_i(cwait), .done_o(conv_done_i), .res_o(conv_result_i));
	task automatic acc(input logic w, input logic [7:0] a, d,
		output logic [7:0] r);
		@(posedge clk_i);
		req <= '{a, d, w, !w};
		@(posedge clk_i);
		req <= '0;
		@(posedge clk_i);
		#1 r = rdata_o;
	endtask
	task automatic chk(input logic [7:0] s, e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("Error at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic test_done;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		repeat (20) @(posedge clk_i);
		nrst_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		acc(1'h0, ADDR_ACQ_CTRL, 8'h00, q);
		chk(q, 8'h20);
		acc(1'h0, ADDR_LIMITS, 8'h00, q);
		chk(q, 8'h78);
		acc(1'h0, 8'h0F, 8'h00, q);
		chk(q, 8'h00);
		foreach (rows[i]) begin
			cwait <= 4'(i) + 4'h4;
			temp <= rows[i][2];
			acc(1'h1, ADDR_LIMITS, rows[i][1], q);
			acc(1'h1, ADDR_ACQ_CTRL, rows[i][0], q);
			acc(1'h0, ADDR_ACQ_CTRL, 8'h00, q);
			chk(q, rows[i][0] & 8'hDF);
			seen = '0;
			repeat (30) begin
				@(posedge clk_i);
				#1 seen = seen | irq_o;
			end
			chk({5'h00, seen}, rows[i][3]);
			acc(1'h0, ADDR_ACQ_CTRL, 8'h00, q);
			chk(q, rows[i][0] & 8'h7F | 8'h20);
		end
		// Zero to the start bit mid-run must not stop it
		cwait <= 4'hF;
		acc(1'h1, ADDR_ACQ_CTRL, 8'h80, q);
		acc(1'h1, ADDR_ACQ_CTRL, 8'h00, q);
		acc(1'h0, ADDR_ACQ_CTRL, 8'h00, q);
		chk(q, 8'h80);
		repeat (30) @(posedge clk_i);
		acc(1'h0, ADDR_ACQ_CTRL, 8'h00, q);
		chk(q, 8'h20);
		test_done;
	end
	initial begin
		#20us;
		errors++;
		test_done;
	end
endmodule // thermistor_temp_monitor_tb
